// >>> logic/cso_pkg.sv
package cso_pkg;
	// instruction classes that can land on a file register
	typedef enum logic [3:0] {
		op_none           = 4'h0,
		move_w_to_file_op = 4'h1,
		add_op            = 4'h2,
		sub_op            = 4'h3,
		and_op            = 4'h4,
		ior_op            = 4'h5,
		xor_op            = 4'h6,
		clear_file_op     = 4'h7,
		rotate_left_op    = 4'h8,
		rotate_right_op   = 4'h9,
		nibble_swap_op    = 4'hA,
		bit_clear_op      = 4'hB,
		bit_set_op        = 4'hC
	} cso_op_type;

	typedef struct packed {
		logic       indirect_bank_sel;
		logic [1:0] direct_bank_sel;
		logic       wdt_expired_n;
		logic       sleep_entered_n;
		logic       zero_flag;
		logic       digit_carry_flag;
		logic       carry_flag;
	} cso_status_type;

	typedef struct packed {
		logic       port_pullup_disable;
		logic       ext_irq_edge;
		logic       timer_src_sel;
		logic       timer_edge_sel;
		logic       prescaler_owner;
		logic [2:0] prescale_ratio;
	} cso_option_type;

	typedef struct packed {
		cso_op_type op;
		logic [6:0] file_addr;
		logic       indirect;
		logic       to_file;
		logic [7:0] w_val;
	} cso_instr_type;

	typedef struct packed {
		logic zero_flag;
		logic digit_carry_flag;
		logic carry_flag;
		logic upd_zero;
		logic upd_digit_carry;
		logic upd_carry;
	} cso_flags_type;

	localparam logic [6:0] STATUS_FILE   = 7'h03;
	localparam logic [6:0] OPTION_FILE   = 7'h01;
	localparam logic [8:0] UNIMPL_LO     = 9'h197;
	localparam logic [8:0] UNIMPL_HI     = 9'h19F;
	localparam int         IND_BANK_BIT  = 7;
	localparam int         DIR_BANK_HI   = 6;
	localparam int         DIR_BANK_LO   = 5;
	localparam int         Z_BIT         = 2;
	localparam int         DIG_CARRY_BIT = 1;
	localparam int         C_BIT         = 0;
	localparam logic [7:0] STATUS_RST    = 8'h18;
	localparam logic [7:0] OPTION_RST    = 8'hFF;
	localparam int         PULLUP_W_DEF  = 6;
	localparam int         PRESCALE_W    = 8;
endpackage : cso_pkg

// >>> logic/cso_flag_unit.sv
`timescale 1ns/1ns
module cso_flag_unit
	import cso_pkg::*;
(
	input  wire cso_op_type    op,
	input  wire logic [7:0]    w_val,
	input  wire logic [7:0]    f_val,
	input  wire logic          carry_in,
	output logic [7:0]         result,
	output cso_flags_type      flags
);
	always_comb begin
		logic [8:0] sum;
		logic [4:0] low;
		sum = 9'h000;
		low = 5'h00;
		result = f_val;
		flags = '0;
		case (op)
			add_op: begin
				sum = {1'h0, f_val} + {1'h0, w_val};
				low = {1'h0, f_val[3:0]} + {1'h0, w_val[3:0]};
				result = sum[7:0];
				flags = '{1'h0, low[4], sum[8], 1'h1, 1'h1, 1'h1};
			end
			sub_op: begin
				// borrow reads as a cleared carry
				sum = {1'h0, f_val} + {1'h0, ~w_val} + 9'h001;
				low = {1'h0, f_val[3:0]} + {1'h0, ~w_val[3:0]} + 5'h01;
				result = sum[7:0];
				flags = '{1'h0, low[4], sum[8], 1'h1, 1'h1, 1'h1};
			end
			and_op: begin
				result = f_val & w_val;
				flags.upd_zero = 1'h1;
			end
			ior_op: begin
				result = f_val | w_val;
				flags.upd_zero = 1'h1;
			end
			xor_op: begin
				result = f_val ^ w_val;
				flags.upd_zero = 1'h1;
			end
			clear_file_op: begin
				result = 8'h00;
				flags.upd_zero = 1'h1;
			end
			rotate_left_op: begin
				result = {f_val[6:0], carry_in};
				flags.carry_flag = f_val[7];
				flags.upd_carry = 1'h1;
			end
			rotate_right_op: begin
				result = {carry_in, f_val[7:1]};
				flags.carry_flag = f_val[0];
				flags.upd_carry = 1'h1;
			end
			move_w_to_file_op: result = w_val;
			nibble_swap_op: result = {f_val[3:0], f_val[7:4]};
			bit_clear_op: result = f_val & ~w_val;
			bit_set_op: result = f_val | w_val;
			default: result = f_val;
		endcase
		flags.zero_flag = (result == 8'h00);
	end
endmodule : cso_flag_unit

// >>> logic/cso_prescale_unit.sv
`timescale 1ns/1ns
module cso_prescale_unit
	import cso_pkg::*;
(
	input  wire logic           ref_clk,
	input  wire logic           srst,
	input  wire logic           ext_timer_irq_pin,
	input  wire logic           instr_clock,
	input  wire logic           wdt_base_tick,
	input  wire cso_option_type cfg,
	output logic                timer_inc,
	output logic                wdt_inc,
	output logic                ext_irq_evt
);
	logic [2:0]            pin_sync;
	logic                  pin_level;
	logic                  next_level;
	logic                  pin_rise;
	logic                  pin_fall;
	logic                  src_evt;
	logic                  pre_in;
	logic                  pre_full;
	logic                  owner_q;
	logic [3:0]            shift;
	logic [8:0]            mask;
	logic [PRESCALE_W-1:0] cnt;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_sync <= 3'h0;
			pin_level <= 1'h0;
		end else begin
			pin_sync <= {pin_sync[1:0], ext_timer_irq_pin};
			pin_level <= next_level;
		end
	end

	// a change counts only once the last two stages agree
	assign next_level = (pin_sync[1] == pin_sync[2]) ? pin_sync[2] : pin_level;
	assign pin_rise = next_level & ~pin_level;
	assign pin_fall = ~next_level & pin_level;
	assign src_evt = cfg.timer_src_sel ? (cfg.timer_edge_sel ? pin_fall : pin_rise)
		: instr_clock;
	assign pre_in = cfg.prescaler_owner ? wdt_base_tick : src_evt;
	assign shift = cfg.prescaler_owner ? {1'h0, cfg.prescale_ratio}
		: {1'h0, cfg.prescale_ratio} + 4'h1;
	assign mask = (9'h001 << shift) - 9'h001;
	assign pre_full = ((cnt[7:0] & mask[7:0]) == mask[7:0]);

	// a reassignment restarts the count so no stale phase leaks across
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt <= '0;
			owner_q <= 1'h1;
		end else begin
			owner_q <= cfg.prescaler_owner;
			if (owner_q != cfg.prescaler_owner) begin
				cnt <= '0;
			end else if (pre_in) begin
				cnt <= cnt + 1'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			timer_inc <= 1'h0;
			wdt_inc <= 1'h0;
			ext_irq_evt <= 1'h0;
		end else begin
			timer_inc <= cfg.prescaler_owner ? src_evt : (src_evt & pre_full);
			wdt_inc <= cfg.prescaler_owner ? (wdt_base_tick & pre_full) : wdt_base_tick;
			ext_irq_evt <= cfg.ext_irq_edge ? pin_rise : pin_fall;
		end
	end

	a_timer_bypass: assert property (@(posedge ref_clk) disable iff (srst)
		(cfg.prescaler_owner && src_evt) |=> timer_inc)
		else $error("timer not clocked 1:1 while prescaler owned by watchdog");
	a_wdt_div_one: assert property (@(posedge ref_clk) disable iff (srst)
		(cfg.prescaler_owner && owner_q && cfg.prescale_ratio == 3'h0 && wdt_base_tick)
		|=> wdt_inc)
		else $error("watchdog ratio zero did not pass every tick");
endmodule : cso_prescale_unit

// >>> logic/cso_core_regs.sv
`timescale 1ns/1ns
module cso_core_regs
	import cso_pkg::*;
#(
	parameter int PULLUP_W = PULLUP_W_DEF
)(
	input  wire logic                ref_clk,
	input  wire logic                srst,
	input  wire logic                instr_valid,
	input  wire cso_instr_type       instr,
	input  wire logic [7:0]          fsr,
	input  wire logic [7:0]          file_rd_data,
	input  wire logic                watchdog_clear_op,
	input  wire logic                sleep_op,
	input  wire logic                wdt_timeout,
	input  wire logic                rd_en,
	input  wire logic [6:0]          rd_file_addr,
	input  wire logic                rd_indirect,
	input  wire logic                ext_timer_irq_pin,
	input  wire logic                instr_clock,
	input  wire logic                wdt_base_tick,
	input  wire logic [PULLUP_W-1:0] pullup_mask_reg,
	output logic [8:0]               data_addr,
	output logic [7:0]               result_data,
	output logic                     result_wr,
	output logic [7:0]               rd_data,
	output logic                     rd_hit,
	output cso_status_type           status_out,
	output cso_option_type           option_out,
	output logic [PULLUP_W-1:0]      pullup_en,
	output logic                     timer_inc,
	output logic                     wdt_inc,
	output logic                     ext_irq_evt
);
	generate
		if (PULLUP_W < 1 || PULLUP_W > 8) begin : g_bad_width
			$error("pull-up width must be 1 to 8");
		end
	endgenerate

	logic           indirect_bank_sel;
	logic [1:0]     direct_bank_sel;
	logic           wdt_expired_n;
	logic           sleep_entered_n;
	logic           zero_flag;
	logic           digit_carry_flag;
	logic           carry_flag;
	cso_option_type option_q;
	cso_status_type status_now;
	logic [8:0]     ex_addr;
	logic [8:0]     rd_addr;
	logic           ex_status;
	logic           ex_option;
	logic           st_wr;
	logic           op_wr;
	logic [7:0]     f_val;
	logic [7:0]     alu_result;
	cso_flags_type  flags;

	// indirect goes through the pointer, direct through the bank bits
	function automatic logic [8:0] cso_form_addr(
		input cso_status_type st,
		input logic [6:0]     file_addr,
		input logic           indirect,
		input logic [7:0]     ptr
	);
		if (indirect) begin
			cso_form_addr = {st.indirect_bank_sel, ptr};
		end else begin
			cso_form_addr = {st.direct_bank_sel, file_addr};
		end
	endfunction : cso_form_addr

	// status is mirrored in every bank
	function automatic logic cso_is_status(input logic [8:0] addr);
		cso_is_status = (addr[6:0] == STATUS_FILE);
	endfunction : cso_is_status

	// option sits in the odd banks only
	function automatic logic cso_is_option(input logic [8:0] addr);
		cso_is_option = (addr[6:0] == OPTION_FILE) && addr[7];
	endfunction : cso_is_option

	function automatic logic cso_is_unimpl(input logic [8:0] addr);
		cso_is_unimpl = (addr >= UNIMPL_LO) && (addr <= UNIMPL_HI);
	endfunction : cso_is_unimpl

	assign status_now = {indirect_bank_sel, direct_bank_sel, wdt_expired_n,
		sleep_entered_n, zero_flag, digit_carry_flag, carry_flag};
	assign status_out = status_now;
	assign option_out = option_q;

	assign ex_addr = cso_form_addr(status_now, instr.file_addr, instr.indirect, fsr);
	assign rd_addr = cso_form_addr(status_now, rd_file_addr, rd_indirect, fsr);
	assign ex_status = cso_is_status(ex_addr);
	assign ex_option = cso_is_option(ex_addr);
	assign st_wr = instr_valid && instr.to_file && ex_status;
	assign op_wr = instr_valid && instr.to_file && ex_option;

	always_comb begin
		if (ex_status) begin
			f_val = status_now;
		end else if (ex_option) begin
			f_val = option_q;
		end else begin
			f_val = file_rd_data;
		end
	end

	cso_flag_unit u_flag_unit (
		.op       (instr.op),
		.w_val    (instr.w_val),
		.f_val    (f_val),
		.carry_in (carry_flag),
		.result   (alu_result),
		.flags    (flags)
	);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			indirect_bank_sel <= STATUS_RST[IND_BANK_BIT];
			direct_bank_sel <= STATUS_RST[DIR_BANK_HI:DIR_BANK_LO];
		end else if (st_wr) begin
			indirect_bank_sel <= alu_result[IND_BANK_BIT];
			direct_bank_sel <= alu_result[DIR_BANK_HI:DIR_BANK_LO];
		end
	end

	// flag logic beats an explicit write to the same bit
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			zero_flag <= STATUS_RST[Z_BIT];
			digit_carry_flag <= STATUS_RST[DIG_CARRY_BIT];
			carry_flag <= STATUS_RST[C_BIT];
		end else if (instr_valid) begin
			if (flags.upd_zero) begin
				zero_flag <= flags.zero_flag;
			end else if (st_wr) begin
				zero_flag <= alu_result[Z_BIT];
			end
			if (flags.upd_digit_carry) begin
				digit_carry_flag <= flags.digit_carry_flag;
			end else if (st_wr) begin
				digit_carry_flag <= alu_result[DIG_CARRY_BIT];
			end
			if (flags.upd_carry) begin
				carry_flag <= flags.carry_flag;
			end else if (st_wr) begin
				carry_flag <= alu_result[C_BIT];
			end
		end
	end

	// no write path at all; a timeout outranks a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wdt_expired_n <= 1'h1;
			sleep_entered_n <= 1'h1;
		end else begin
			if (wdt_timeout) begin
				wdt_expired_n <= 1'h0;
			end else if (watchdog_clear_op || sleep_op) begin
				wdt_expired_n <= 1'h1;
			end
			if (sleep_op) begin
				sleep_entered_n <= 1'h0;
			end else if (watchdog_clear_op) begin
				sleep_entered_n <= 1'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			option_q <= OPTION_RST;
		end else if (op_wr) begin
			option_q <= alu_result;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			data_addr <= 9'h000;
			result_data <= 8'h00;
			result_wr <= 1'h0;
		end else begin
			if (instr_valid) begin
				data_addr <= ex_addr;
				result_data <= alu_result;
			end
			result_wr <= instr_valid && instr.to_file && !ex_status && !ex_option;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rd_data <= 8'h00;
			rd_hit <= 1'h0;
		end else if (!rd_en) begin
			rd_hit <= 1'h0;
		end else if (cso_is_status(rd_addr)) begin
			rd_data <= status_now;
			rd_hit <= 1'h1;
		end else if (cso_is_option(rd_addr)) begin
			rd_data <= option_q;
			rd_hit <= 1'h1;
		end else if (cso_is_unimpl(rd_addr)) begin
			rd_data <= 8'h00;
			rd_hit <= 1'h1;
		end else begin
			rd_data <= 8'h00;
			rd_hit <= 1'h0;
		end
	end

	// registered so the pad ring sees a clean level
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pullup_en <= '0;
		end else if (option_q.port_pullup_disable) begin
			pullup_en <= '0;
		end else begin
			pullup_en <= pullup_mask_reg;
		end
	end

	cso_prescale_unit u_prescale_unit (
		.ref_clk           (ref_clk),
		.srst              (srst),
		.ext_timer_irq_pin (ext_timer_irq_pin),
		.instr_clock       (instr_clock),
		.wdt_base_tick     (wdt_base_tick),
		.cfg               (option_q),
		.timer_inc         (timer_inc),
		.wdt_inc           (wdt_inc),
		.ext_irq_evt       (ext_irq_evt)
	);

	a_flag_write_block: assert property (@(posedge ref_clk) disable iff (srst)
		(st_wr && flags.upd_zero) |=> (zero_flag == $past(flags.zero_flag)))
		else $error("explicit write reached a flag the op owns");
	a_status_ro_bits: assert property (@(posedge ref_clk) disable iff (srst)
		(st_wr && !wdt_timeout && !watchdog_clear_op && !sleep_op)
		|=> $stable(wdt_expired_n) && $stable(sleep_entered_n))
		else $error("status write changed a read-only flag");
	a_timeout_clears: assert property (@(posedge ref_clk) disable iff (srst)
		wdt_timeout |=> !wdt_expired_n)
		else $error("timeout did not clear watchdog flag");
	a_clear_sets: assert property (@(posedge ref_clk) disable iff (srst)
		(watchdog_clear_op && !wdt_timeout && !sleep_op)
		|=> wdt_expired_n && sleep_entered_n)
		else $error("watchdog clear did not set both flags");
	a_sleep_marks: assert property (@(posedge ref_clk) disable iff (srst)
		(sleep_op && !wdt_timeout) |=> !sleep_entered_n && wdt_expired_n)
		else $error("sleep did not mark power-down");
	a_unimpl_reads: assert property (@(posedge ref_clk) disable iff (srst)
		(rd_en && cso_is_unimpl(rd_addr)) |=> rd_hit && (rd_data == 8'h00))
		else $error("unimplemented location read nonzero");
	a_pullup_gate: assert property (@(posedge ref_clk) disable iff (srst)
		##1 (pullup_en == ($past(option_q.port_pullup_disable) ? '0 : $past(pullup_mask_reg))))
		else $error("pull-up enables disagree with disable bit");
	a_direct_addr: assert property (@(posedge ref_clk) disable iff (srst)
		(instr_valid && !instr.indirect)
		|=> (data_addr == {$past(direct_bank_sel), $past(instr.file_addr)}))
		else $error("direct address not formed from bank bits");
	a_indirect_addr: assert property (@(posedge ref_clk) disable iff (srst)
		(instr_valid && instr.indirect)
		|=> (data_addr == {$past(indirect_bank_sel), $past(fsr)}))
		else $error("indirect address not formed from bank bit");
	a_zero_track: assert property (@(posedge ref_clk) disable iff (srst)
		(instr_valid && flags.upd_zero) |=> (zero_flag == ($past(alu_result) == 8'h00)))
		else $error("zero flag does not match result");
	a_sub_borrow: assert property (@(posedge ref_clk) disable iff (srst)
		(instr_valid && instr.op == sub_op)
		|=> (carry_flag == ($past(f_val) >= $past(instr.w_val))))
		else $error("subtract carry is not inverted borrow");
	a_rotate_carry: assert property (@(posedge ref_clk) disable iff (srst)
		(instr_valid && instr.op == rotate_left_op) |=> (carry_flag == $past(f_val[7])))
		else $error("rotate left lost the shifted bit");
endmodule : cso_core_regs

// >>> tb/cso_core_regs_tb.sv
`timescale 1ns/1ns
module cso_core_regs_tb
	import cso_pkg::*;
;
	logic          ref_clk;
	logic          srst;
	logic          instr_valid;
	cso_instr_type instr;
	logic [7:0]    fsr;
	logic [7:0]    file_rd_data;
	logic          watchdog_clear_op;
	logic          sleep_op;
	logic          wdt_timeout;
	logic          rd_en;
	logic [6:0]    rd_file_addr;
	logic          rd_indirect;
	logic          ext_timer_irq_pin;
	logic          instr_clock;
	logic          wdt_base_tick;
	logic [5:0]    pullup_mask_reg;
	logic [8:0]    data_addr;
	logic [7:0]    result_data;
	logic          result_wr;
	logic [7:0]    rd_data;
	logic          rd_hit;
	cso_status_type status_out;
	cso_option_type option_out;
	logic [5:0]    pullup_en;
	logic          timer_inc;
	logic          wdt_inc;
	logic          ext_irq_evt;
	int            errors;
	int            comparisons;
	int            tcnt;
	int            wcnt;

	cso_core_regs cso_core_regs_inst (
		.ref_clk(ref_clk), .srst(srst), .instr_valid(instr_valid), .instr(instr), .fsr(fsr),
		.file_rd_data(file_rd_data), .watchdog_clear_op(watchdog_clear_op),
		.sleep_op(sleep_op), .wdt_timeout(wdt_timeout), .rd_en(rd_en),
		.rd_file_addr(rd_file_addr), .rd_indirect(rd_indirect),
		.ext_timer_irq_pin(ext_timer_irq_pin), .instr_clock(instr_clock),
		.wdt_base_tick(wdt_base_tick), .pullup_mask_reg(pullup_mask_reg),
		.data_addr(data_addr), .result_data(result_data), .result_wr(result_wr),
		.rd_data(rd_data), .rd_hit(rd_hit), .status_out(status_out),
		.option_out(option_out), .pullup_en(pullup_en), .timer_inc(timer_inc),
		.wdt_inc(wdt_inc), .ext_irq_evt(ext_irq_evt)
	);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// pulse counters sample the registered outputs at the edge, so no race with the design
	always @(posedge ref_clk) begin
		if (!srst) begin
			tcnt <= tcnt + int'(timer_inc);
			wcnt <= wcnt + int'(wdt_inc);
		end
	end

	task automatic end_sim;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic exec(input cso_op_type o, input logic [6:0] fa, input logic ind,
		input logic tf, input logic [7:0] w, input logic [7:0] f);
		@(posedge ref_clk);
		instr_valid  <= 1'b1;
		instr        <= '{op: o, file_addr: fa, indirect: ind, to_file: tf, w_val: w};
		file_rd_data <= f;
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		#1;
	endtask : exec

	task automatic pulse_ev(input logic [2:0] m);
		@(posedge ref_clk);
		{watchdog_clear_op, sleep_op, wdt_timeout} <= m;
		@(posedge ref_clk);
		{watchdog_clear_op, sleep_op, wdt_timeout} <= 3'h0;
		#1;
	endtask : pulse_ev

	task automatic rd(input logic [6:0] a, input logic ind, input logic hit, input logic [7:0] d);
		@(posedge ref_clk);
		rd_en        <= 1'b1;
		rd_file_addr <= a;
		rd_indirect  <= ind;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		chk({8'h00, rd_hit}, {8'h00, hit});
		chk({1'b0, rd_data}, {1'b0, d});
	endtask : rd

	task automatic set_opt(input logic [7:0] v);
		exec(move_w_to_file_op, OPTION_FILE, 1'b0, 1'b1, v, 8'h00);
		chk({1'b0, option_out}, {1'b0, v});
	endtask : set_opt

	// waits a bounded number of cycles for an interrupt event after moving the pin
	task automatic edge_evt(input logic lvl, input logic exp);
		logic seen;
		seen = 1'b0;
		@(posedge ref_clk);
		ext_timer_irq_pin <= lvl;
		repeat (10) begin
			@(posedge ref_clk);
			#1;
			if (ext_irq_evt === 1'b1) seen = 1'b1;
		end
		chk({8'h00, seen}, {8'h00, exp});
	endtask : edge_evt

	// pin mode ends with the pin high, so rising edges outnumber falling ones by one
	task automatic run_ticks(input int n, input bit pin, input int et, input int ew);
		int t0;
		int w0;
		int k;
		k = pin ? 8 : 1;
		t0 = tcnt;
		w0 = wcnt;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			if (pin) ext_timer_irq_pin <= 1'b1;
			else {instr_clock, wdt_base_tick} <= 2'h3;
			repeat (k) @(posedge ref_clk);
			ext_timer_irq_pin <= 1'b0;
			{instr_clock, wdt_base_tick} <= 2'h0;
			repeat (k - 1) @(posedge ref_clk);
		end
		if (pin) ext_timer_irq_pin <= 1'b1;
		repeat (12) @(posedge ref_clk);
		#1;
		chk(9'(tcnt - t0), 9'(et));
		chk(9'(wcnt - w0), 9'(ew));
		@(posedge ref_clk);
		ext_timer_irq_pin <= 1'b0;
		repeat (12) @(posedge ref_clk);
	endtask : run_ticks

	initial begin
		#400000;
		errors++;
		end_sim();
	end

	initial begin
		srst = 1'b1; instr_valid = 1'b0; instr = '0; fsr = 8'h00; file_rd_data = 8'h00;
		{watchdog_clear_op, sleep_op, wdt_timeout} = 3'h0;
		rd_en = 1'b0; rd_file_addr = 7'h00; rd_indirect = 1'b0;
		ext_timer_irq_pin = 1'b0; instr_clock = 1'b0; wdt_base_tick = 1'b0;
		pullup_mask_reg = 6'h2A; tcnt = 0; wcnt = 0; errors = 0; comparisons = 0;
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		#1;
		chk({1'b0, status_out}, {1'b0, STATUS_RST});
		chk({1'b0, option_out}, {1'b0, OPTION_RST});
		chk({3'h0, pullup_en}, 9'h000);
		exec(clear_file_op, STATUS_FILE, 1'b0, 1'b1, 8'h00, 8'h00);
		chk({1'b0, status_out}, 9'h01C);
		chk({8'h00, result_wr}, 9'h000);
		pulse_ev(3'b010);
		chk({1'b0, status_out}, 9'h014);
		exec(move_w_to_file_op, STATUS_FILE, 1'b0, 1'b1, 8'hFF, 8'h00);
		chk({1'b0, status_out}, 9'h0F7);
		pulse_ev(3'b001);
		chk({1'b0, status_out}, 9'h0E7);
		pulse_ev(3'b100);
		chk({1'b0, status_out}, 9'h0FF);
		exec(move_w_to_file_op, STATUS_FILE, 1'b0, 1'b1, 8'h00, 8'h00);
		chk({1'b0, status_out}, 9'h018);
		exec(add_op, 7'h20, 1'b0, 1'b0, 8'h0F, 8'h01);
		chk({1'b0, result_data}, 9'h010);
		chk({1'b0, status_out}, 9'h01A);
		chk(data_addr, 9'h020);
		exec(and_op, 7'h20, 1'b0, 1'b1, 8'h0F, 8'h3C);
		chk({8'h00, result_wr}, 9'h001);
		chk({1'b0, result_data}, 9'h00C);
		chk({1'b0, status_out}, 9'h01A);
		exec(add_op, 7'h20, 1'b0, 1'b0, 8'hFF, 8'h01);
		chk({1'b0, status_out}, 9'h01F);
		exec(sub_op, 7'h20, 1'b0, 1'b0, 8'h03, 8'h05);
		chk({1'b0, result_data}, 9'h002);
		chk({1'b0, status_out}, 9'h01B);
		exec(sub_op, 7'h20, 1'b0, 1'b0, 8'h05, 8'h03);
		chk({1'b0, result_data}, 9'h0FE);
		chk({1'b0, status_out}, 9'h018);
		exec(rotate_left_op, 7'h20, 1'b0, 1'b0, 8'h00, 8'h80);
		chk({1'b0, status_out}, 9'h019);
		exec(rotate_right_op, 7'h20, 1'b0, 1'b0, 8'h00, 8'h02);
		chk({1'b0, result_data}, 9'h081);
		chk({1'b0, status_out}, 9'h018);
		exec(move_w_to_file_op, STATUS_FILE, 1'b0, 1'b1, 8'h60, 8'h00);
		exec(and_op, 7'h20, 1'b0, 1'b0, 8'hFF, 8'h01);
		chk(data_addr, 9'h1A0);
		chk({1'b0, status_out}, 9'h078);
		exec(move_w_to_file_op, STATUS_FILE, 1'b0, 1'b1, 8'h80, 8'h00);
		fsr <= 8'h34;
		exec(and_op, 7'h00, 1'b1, 1'b0, 8'h00, 8'h01);
		chk(data_addr, 9'h134);
		chk({1'b0, status_out}, 9'h09C);
		for (int a = 8'h97; a <= 8'h9F; a++) begin
			fsr <= 8'(a);
			rd(7'h00, 1'b1, 1'b1, 8'h00);
		end
		fsr <= 8'hA0;
		rd(7'h00, 1'b1, 1'b0, 8'h00);
		rd(STATUS_FILE, 1'b0, 1'b1, 8'h9C);
		exec(move_w_to_file_op, STATUS_FILE, 1'b0, 1'b1, 8'h20, 8'h00);
		set_opt(8'h40);
		repeat (2) @(posedge ref_clk);
		#1;
		chk({3'h0, pullup_en}, 9'h02A);
		set_opt(8'hC0);
		repeat (2) @(posedge ref_clk);
		#1;
		chk({3'h0, pullup_en}, 9'h000);
		edge_evt(1'b1, 1'b1);
		edge_evt(1'b0, 1'b0);
		set_opt(8'h00);
		edge_evt(1'b1, 1'b0);
		edge_evt(1'b0, 1'b1);
		set_opt(8'h40);
		run_ticks(16, 1'b0, 8, 16);
		set_opt(8'h42);
		run_ticks(16, 1'b0, 2, 16);
		set_opt(8'h4A);
		run_ticks(16, 1'b0, 16, 4);
		set_opt(8'h7A);
		run_ticks(4, 1'b1, 4, 0);
		set_opt(8'h6A);
		run_ticks(4, 1'b1, 5, 0);
		end_sim();
	end
endmodule : cso_core_regs_tb
